/* hw/tcp_prescaler.sv */
// Purpose: divides the timer clock by the shadow prescale value plus one
// Assumes: update is a one-cycle pulse from the update event logic
// Notes: tick is a one-cycle counter clock enable
module tcp_prescaler import tcp_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // link to the register block
    tcp_psc_if.div psc
);

    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] shadow_reg;
    logic wrap;

    // divider ends its period when the count reaches the shadow value
    assign wrap = (count_reg == shadow_reg);
    assign count_next = (psc.update || wrap) ? 16'h0000 : count_reg + 16'h0001;
    assign psc.tick = wrap;
    assign psc.shadow_value = shadow_reg;

    // prescale count, restarted by every update event
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= PSC_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // new prescale value only reaches the divider on an update event
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shadow_reg <= PSC_RESET;
        end else if (psc.update) begin
            shadow_reg <= psc.prescale_value;
        end
    end

    div_restart_a: assert property (@(posedge clk) disable iff (!resetn)
        (psc.tick && !psc.update) |=> (count_reg == 16'h0000) && !psc.tick || shadow_reg == 16'h0)
        else $error("divider did not restart after a tick");
    shadow_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        !psc.update |=> $stable(shadow_reg))
        else $error("shadow prescale changed without an update event");
    shadow_load_a: assert property (@(posedge clk) disable iff (!resetn)
        psc.update |=> shadow_reg == $past(psc.prescale_value))
        else $error("shadow prescale not loaded on update event");

endmodule // tcp_prescaler

/* hw/tcp_timer.sv */
// Purpose: channel 0 enable and polarity, counter value and counter clock prescaler
// Assumes: lock level, update event and channel edge come from timer logic on clk
// Notes: WIDE selects the 32-bit counter instance, else the counter is 16 bits
//
// Functional notes
// - Writes to both channel 0 polarity bits are ignored while the lock level is 11 or 10.
// - In output mode polarity 0 gives an active high output and 1 an active low one.
// - In input mode the bit pair picks rising, falling with inversion, reserved or both.
// - In output mode the enable bit lets the output go active and clearing it disables it.
// - The counter reads live, loads on a write, and is 32 or 16 bits wide by instance.
// - The counter clock is the input clock divided by the prescale value plus one.
// - A written prescale value acts only after the next update event copies it.
// - Counter and prescale registers take half-word and word accesses alike.
module tcp_timer import tcp_pkg::*; #(
    parameter bit WIDE = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // timer context
    input wire logic [1:0] lock_level,
    input wire logic update_event,
    input wire logic counter_run,
    input wire logic chan0_input_mode,
    input wire logic chan0_filtered_edge,
    input wire logic oc_ref,
    // channel 0 results
    output logic chan0_output,
    output logic chan0_trigger,
    output logic chan0_capture,
    // counter state
    output logic [DATA_W-1:0] counter_value,
    output logic [15:0] prescale_shadow
);

    // merge written byte lanes over an old value
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] lanes);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    // active edge chosen by complementary and normal polarity bits
    function automatic tcp_edge_type decode_edge(input logic comp_pol, input logic pol);
        tcp_edge_type sel;
        case ({comp_pol, pol})
            2'b00: sel = EDGE_RISE;
            2'b01: sel = EDGE_FALL;
            2'b11: sel = EDGE_BOTH;
            default: sel = EDGE_NONE;
        endcase
        return sel;
    endfunction

    tcp_psc_if psc_link ();

    tcp_bus_type bus_state_reg;
    tcp_bus_type bus_state_next;
    logic [DATA_W-1:0] readdata_reg;
    logic [DATA_W-1:0] readdata_next;
    logic [31:0] counter_reg;
    logic [31:0] counter_next;
    logic [15:0] psc_reg;
    logic [15:0] psc_next;
    logic [15:0] chen_reg;
    logic [15:0] chen_next;
    logic edge_prev_reg;
    logic output_reg;
    logic output_next;
    logic trigger_reg;
    logic trigger_next;
    logic capture_reg;
    logic capture_next;

    logic request;
    logic accept;
    logic sel_chen;
    logic sel_cnt;
    logic sel_psc;
    logic wr_chen;
    logic wr_cnt;
    logic wr_psc;
    logic locked;
    logic [31:0] cnt_mask;
    logic [31:0] cnt_written;
    logic [31:0] psc_written;
    logic [31:0] chen_written;
    logic [15:0] chen_wmask;
    logic [DATA_W-1:0] read_mux;
    logic ch_en;
    logic ch_pol;
    logic ch_comp_pol;
    tcp_edge_type edge_sel;
    logic edge_rise;
    logic edge_fall;
    logic edge_hit;

    // address decode of the three mapped words
    assign sel_chen = (avs_address == CHEN_OFFSET);
    assign sel_cnt = (avs_address == CNT_OFFSET);
    assign sel_psc = (avs_address == PSC_OFFSET);

    // every access is answered on its second cycle
    assign request = avs_read || avs_write;
    assign accept = request && (bus_state_reg == BUS_ACK);
    assign avs_waitrequest = request && (bus_state_reg != BUS_ACK);
    assign bus_state_next = (bus_state_reg == BUS_IDLE && request) ? BUS_ACK : BUS_IDLE;

    // write strobes, taken at the edge where waitrequest is low
    assign wr_chen = accept && avs_write && sel_chen;
    assign wr_cnt = accept && avs_write && sel_cnt;
    assign wr_psc = accept && avs_write && sel_psc;

    // bus sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_state_reg <= BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // read multiplexer, narrow fields sit in the low bits
    assign read_mux = sel_chen ? {16'h0000, chen_reg} :
                      sel_cnt ? counter_reg :
                      sel_psc ? {16'h0000, psc_reg} : UNMAPPED_DATA;
    assign readdata_next = (bus_state_reg == BUS_IDLE && avs_read) ? read_mux : readdata_reg;

    // read data captured in the first cycle and held through the answer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readdata_reg <= 32'h0000_0000;
        end else begin
            readdata_reg <= readdata_next;
        end
    end
    assign avs_readdata = readdata_reg;

    // counter: bus write wins over a counter clock tick
    assign cnt_mask = WIDE ? CNT_MASK_WIDE : CNT_MASK_NARROW;
    assign cnt_written = merge_lanes(counter_reg, avs_writedata, avs_byteenable);
    assign counter_next = wr_cnt ? (cnt_written & cnt_mask) :
                          (counter_run && psc_link.tick) ? ((counter_reg + 32'h1) & cnt_mask) :
                          counter_reg;

    // counter register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            counter_reg <= CNT_RESET;
        end else begin
            counter_reg <= counter_next;
        end
    end
    assign counter_value = counter_reg;

    // prescale value, a word or half-word write lands in the low half
    assign psc_written = merge_lanes({16'h0000, psc_reg}, avs_writedata, avs_byteenable);
    assign psc_next = wr_psc ? psc_written[15:0] : psc_reg;

    // prescale register, reaches the divider through its shadow copy
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            psc_reg <= PSC_RESET;
        end else begin
            psc_reg <= psc_next;
        end
    end

    // divider link
    assign psc_link.prescale_value = psc_reg;
    assign psc_link.update = update_event;
    assign prescale_shadow = psc_link.shadow_value;

    tcp_prescaler u_prescaler (
        .clk(clk),
        .resetn(resetn),
        .psc(psc_link.div)
    );

    // channel enable write, polarity bits frozen at lock levels 11 and 10
    assign locked = lock_level[1];
    assign chen_wmask = locked ? CHEN_WMASK_LOCK : CHEN_WMASK_OPEN;
    assign chen_written = merge_lanes({16'h0000, chen_reg}, avs_writedata, avs_byteenable);
    assign chen_next = wr_chen ? ((chen_reg & ~chen_wmask) | (chen_written[15:0] & chen_wmask))
                               : chen_reg;

    // channel enable and polarity register, reserved and foreign bits stay zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chen_reg <= CHEN_RESET;
        end else begin
            chen_reg <= chen_next;
        end
    end

    // field views
    assign ch_en = chen_reg[CH0_EN_BIT];
    assign ch_pol = chen_reg[CH0_POL_BIT];
    assign ch_comp_pol = chen_reg[CH0_COMP_POL_BIT];

    // input edge selection; falling edge is seen as the rising edge of the inverted input
    assign edge_sel = decode_edge(ch_comp_pol, ch_pol);
    assign edge_rise = chan0_filtered_edge && !edge_prev_reg;
    assign edge_fall = !chan0_filtered_edge && edge_prev_reg;
    assign edge_hit = (edge_sel == EDGE_RISE && edge_rise) ||
                      (edge_sel == EDGE_FALL && edge_fall) ||
                      (edge_sel == EDGE_BOTH && (edge_rise || edge_fall));

    // trigger follows the chosen edge, capture also needs the enable bit
    assign trigger_next = chan0_input_mode && edge_hit;
    assign capture_next = chan0_input_mode && edge_hit && ch_en;

    // output sense, inactive low while the channel is disabled
    assign output_next = (!chan0_input_mode && ch_en) ? (oc_ref ^ ch_pol) : 1'b0;

    // channel 0 flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            edge_prev_reg <= 1'b0;
            output_reg <= 1'b0;
            trigger_reg <= 1'b0;
            capture_reg <= 1'b0;
        end else begin
            edge_prev_reg <= chan0_filtered_edge;
            output_reg <= output_next;
            trigger_reg <= trigger_next;
            capture_reg <= capture_next;
        end
    end
    assign chan0_output = output_reg;
    assign chan0_trigger = trigger_reg;
    assign chan0_capture = capture_reg;

    // checks on the register and channel behaviour
    lock_holds_polarity_a: assert property (@(posedge clk) disable iff (!resetn)
        (wr_chen && locked) |=> (chen_reg[CH0_POL_BIT] == $past(chen_reg[CH0_POL_BIT])) &&
            (chen_reg[CH0_COMP_POL_BIT] == $past(chen_reg[CH0_COMP_POL_BIT])))
        else $error("polarity bits changed under lock");

    open_write_polarity_a: assert property (@(posedge clk) disable iff (!resetn)
        (wr_chen && !locked && avs_byteenable[0]) |=>
            chen_reg[CH0_POL_BIT] == $past(avs_writedata[CH0_POL_BIT]))
        else $error("unlocked polarity write lost");

    output_sense_a: assert property (@(posedge clk) disable iff (!resetn)
        (!chan0_input_mode && ch_en) |=> chan0_output == ($past(oc_ref) ^ $past(ch_pol)))
        else $error("channel output sense wrong");

    output_disabled_a: assert property (@(posedge clk) disable iff (!resetn)
        (!chan0_input_mode && !ch_en) |=> !chan0_output)
        else $error("disabled channel output went active");

    rising_capture_a: assert property (@(posedge clk) disable iff (!resetn)
        (chan0_input_mode && edge_sel == EDGE_RISE && ch_en &&
            !edge_prev_reg && chan0_filtered_edge) |=> chan0_capture)
        else $error("rising edge capture missed");

    falling_only_a: assert property (@(posedge clk) disable iff (!resetn)
        (edge_sel == EDGE_FALL && edge_rise) |=> !chan0_trigger)
        else $error("rising edge triggered in falling mode");

    reserved_pair_a: assert property (@(posedge clk) disable iff (!resetn)
        (edge_sel == EDGE_NONE) |=> !chan0_trigger)
        else $error("reserved polarity pair produced a trigger");

    capture_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        chan0_capture |-> $past(ch_en) && chan0_trigger)
        else $error("capture without channel enable");

    counter_load_a: assert property (@(posedge clk) disable iff (!resetn)
        (wr_cnt && avs_byteenable == 4'hf) |=> counter_value == ($past(avs_writedata) & cnt_mask))
        else $error("counter write not loaded");

    counter_tick_a: assert property (@(posedge clk) disable iff (!resetn)
        (!wr_cnt && !(counter_run && psc_link.tick)) |=> $stable(counter_reg))
        else $error("counter moved without a counter clock tick");

    half_write_a: assert property (@(posedge clk) disable iff (!resetn)
        (wr_cnt && avs_byteenable == 4'hc) |=> counter_reg[15:0] == $past(counter_reg[15:0]))
        else $error("upper half-word write disturbed the low half");

    psc_word_write_a: assert property (@(posedge clk) disable iff (!resetn)
        (wr_psc && avs_byteenable[1:0] == 2'b11) |=> psc_reg == $past(avs_writedata[15:0]))
        else $error("prescale write not stored");

    answer_timing_a: assert property (@(posedge clk) disable iff (!resetn)
        (request && bus_state_reg == BUS_IDLE) |=> !avs_waitrequest || !request)
        else $error("slave did not answer on the second cycle");

    reset_clear_a: assert property (@(posedge clk)
        !resetn |=> (chen_reg == CHEN_RESET) && (psc_reg == PSC_RESET))
        else $error("registers not cleared by reset");

    narrow_width_a: assert property (@(posedge clk) disable iff (!resetn)
        !WIDE |-> counter_reg[31:16] == 16'h0000)
        else $error("narrow counter grew past 16 bits");

    trigger_mode_a: assert property (@(posedge clk) disable iff (!resetn)
        chan0_trigger |-> $past(chan0_input_mode))
        else $error("trigger pulse outside input mode");

    fall_capture_a: assert property (@(posedge clk) disable iff (!resetn)
        (chan0_input_mode && edge_sel == EDGE_FALL && ch_en && edge_fall) |=> chan0_capture)
        else $error("falling edge capture missed");

    both_edges_a: assert property (@(posedge clk) disable iff (!resetn)
        (chan0_input_mode && edge_sel == EDGE_BOTH && (edge_rise || edge_fall)) |=>
            chan0_trigger)
        else $error("edge missed in both edge mode");

    capture_off_a: assert property (@(posedge clk) disable iff (!resetn)
        !ch_en |=> !chan0_capture)
        else $error("capture with channel disabled");

    lock_enable_a: assert property (@(posedge clk) disable iff (!resetn)
        (wr_chen && locked && avs_byteenable[0]) |=>
            chen_reg[CH0_EN_BIT] == $past(avs_writedata[CH0_EN_BIT]))
        else $error("enable bit write lost under lock");

    count_step_a: assert property (@(posedge clk) disable iff (!resetn)
        (!wr_cnt && counter_run && psc_link.tick) |=>
            counter_reg == (($past(counter_reg) + 32'h1) & cnt_mask))
        else $error("counter did not step on a tick");

    prescale_lanes_a: assert property (@(posedge clk) disable iff (!resetn)
        (wr_psc && avs_byteenable[1:0] == 2'b00) |=> $stable(psc_reg))
        else $error("prescale changed by an upper lane write");

endmodule // tcp_timer

/* include/tcp_pkg.sv */
// Purpose: shared constants and types of the timer channel 0, counter and prescaler block
// Assumes: byte addressed Avalon-MM slave with 32-bit data
// Notes: every offset, field position, mapped register reset value and mask lives here
package tcp_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] CHEN_OFFSET = 8'h20;
    localparam logic [ADDR_W-1:0] CNT_OFFSET = 8'h24;
    localparam logic [ADDR_W-1:0] PSC_OFFSET = 8'h28;

    // channel enable and polarity field positions
    localparam int CH0_EN_BIT = 0;
    localparam int CH0_POL_BIT = 1;
    localparam int CH0_RSVD_BIT = 2;
    localparam int CH0_COMP_POL_BIT = 3;

    // writable bits of the channel enable register, unlocked and locked
    localparam logic [15:0] CHEN_WMASK_OPEN = 16'h000b;
    localparam logic [15:0] CHEN_WMASK_LOCK = 16'h0001;

    // values after reset
    localparam logic [15:0] CHEN_RESET = 16'h0000;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [15:0] PSC_RESET = 16'h0000;

    // counter width masks of the wide and the narrow instance
    localparam logic [31:0] CNT_MASK_WIDE = 32'hffff_ffff;
    localparam logic [31:0] CNT_MASK_NARROW = 32'h0000_ffff;

    // answer to an unmapped read
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // active edge chosen by the two polarity bits
    typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_NONE, EDGE_BOTH} tcp_edge_type;

    // bus answer sequencer
    typedef enum logic {BUS_IDLE, BUS_ACK} tcp_bus_type;

endpackage

/* include/tcp_psc_if.sv */
// Purpose: link between the register block and the counter clock divider
// Assumes: both ends run on the same timer clock
// Notes: the divider owns the shadow copy of the prescale value
interface tcp_psc_if;
    logic [15:0] prescale_value;
    logic update;
    logic tick;
    logic [15:0] shadow_value;

    // register side
    modport ctrl (output prescale_value, output update, input tick, input shadow_value);
    // divider side
    modport div (input prescale_value, input update, output tick, output shadow_value);
endinterface

/* tb/test_timer_channel0_counter_prescaler.sv */
// Purpose: self-checking bench for the channel 0, counter and prescaler block
// Assumes: the slave answers within twenty cycles; a narrow twin shares every input
// Notes: bus tasks end on a rising edge so the next request starts cleanly
module test_timer_channel0_counter_prescaler import tcp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // clock, reset and bus
    logic clk;
    logic resetn;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [BE_W-1:0] avs_byteenable;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    // timer context and results
    logic [1:0] lock_level;
    logic update_event;
    logic counter_run;
    logic chan0_input_mode;
    logic chan0_filtered_edge;
    logic oc_ref;
    logic chan0_output;
    logic chan0_trigger;
    logic chan0_capture;
    logic [DATA_W-1:0] counter_value;
    logic [DATA_W-1:0] counter_narrow;
    logic [15:0] prescale_shadow;
    // bench state
    int mismatches;
    int compares;
    logic [31:0] rdata;
    logic [3:0] nt;
    logic [3:0] nc;
    logic er;
    logic ef;

    // wide and narrow instances driven by the same stimulus
    tcp_timer #(.WIDE(1'b1)) dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lock_level(lock_level),
        .update_event(update_event), .counter_run(counter_run),
        .chan0_input_mode(chan0_input_mode), .chan0_filtered_edge(chan0_filtered_edge),
        .oc_ref(oc_ref), .chan0_output(chan0_output), .chan0_trigger(chan0_trigger),
        .chan0_capture(chan0_capture), .counter_value(counter_value),
        .prescale_shadow(prescale_shadow));
    tcp_timer #(.WIDE(1'b0)) dut_narrow (.clk(clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(), .avs_waitrequest(),
        .lock_level(lock_level), .update_event(update_event), .counter_run(counter_run),
        .chan0_input_mode(chan0_input_mode), .chan0_filtered_edge(chan0_filtered_edge),
        .oc_ref(oc_ref), .chan0_output(), .chan0_trigger(), .chan0_capture(),
        .counter_value(counter_narrow), .prescale_shadow());

    // 200 MHz timer clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // comparison with four-state equality
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic summarize();
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one avalon access held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic rd, input logic [7:0] addr, input logic [31:0] data,
                       input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= addr;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= data;
        avs_byteenable <= be;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk("bus_answer", 32'h0000_0000, {31'h0, avs_waitrequest});
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] be);
        bus(1'b0, addr, data, be);
    endtask

    task automatic rd(input logic [7:0] addr);
        bus(1'b1, addr, 32'h0000_0000, 4'hf);
    endtask

    // reset, then every register and state output must read zero
    task automatic reset_check();
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(CHEN_OFFSET);
        chk("chan_reg_reset", 32'h0000_0000, rdata); // cleared
        rd(CNT_OFFSET);
        chk("counter_reset", 32'h0000_0000, rdata); // cleared
        rd(PSC_OFFSET);
        chk("prescale_reset", 32'h0000_0000, rdata); // cleared
        chk("shadow_reset", 32'h0000_0000, {16'h0000, prescale_shadow});
    endtask

    // let the counter run for n edges with the current divider
    task automatic run_ticks(input int n);
        counter_run <= 1'b1;
        repeat (n) @(posedge clk);
        counter_run <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pulse_update();
        update_event <= 1'b1;
        @(posedge clk);
        update_event <= 1'b0;
        @(posedge clk);
    endtask

    // move the channel input and count trigger and capture pulses
    task automatic edge_run(input logic v);
        chan0_filtered_edge <= v;
        nt = 4'h0;
        nc = 4'h0;
        repeat (4) begin
            @(negedge clk);
            nt = nt + chan0_trigger;
            nc = nc + chan0_capture;
        end
        @(posedge clk);
    endtask

    // main sequence
    initial begin
        mismatches = 0;
        compares = 0;
        resetn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        lock_level = 2'h0;
        update_event = 1'b0;
        counter_run = 1'b0;
        chan0_input_mode = 1'b0;
        chan0_filtered_edge = 1'b0;
        oc_ref = 1'b0;
        reset_check();
        rd(8'h30);
        chk("unmapped", 32'h0000_0000, rdata);
        // reserved bit written at its reset value
        wr(CHEN_OFFSET, 32'h0000_000b, 4'hf);
        rd(CHEN_OFFSET);
        chk("chan_reg", 32'h0000_000b, rdata); // reserved bit reads 0
        // both locked levels freeze the polarity bits only
        for (int l = 2; l < 4; l++) begin
            lock_level <= l[1:0];
            wr(CHEN_OFFSET, 32'h0000_0000, 4'hf);
            rd(CHEN_OFFSET);
            chk("chan_reg_locked", 32'h0000_000a, rdata);
        end
        lock_level <= 2'h0;
        wr(CHEN_OFFSET, 32'h0000_0000, 4'hf);
        rd(CHEN_OFFSET);
        chk("chan_reg_open", 32'h0000_0000, rdata); // unlocked write
        // output mode: every enable, polarity and reference level
        for (int i = 0; i < 8; i++) begin
            wr(CHEN_OFFSET, {30'h0, i[1], i[0]}, 4'hf); // complementary kept 0
            oc_ref <= i[2];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("output", {31'h0, i[0] & (i[2] ^ i[1])}, {31'h0, chan0_output});
            @(posedge clk);
        end
        // input mode: every polarity pair with and without enable
        chan0_input_mode <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(CHEN_OFFSET, {28'h0, i[2], 1'b0, i[1], i[0]}, 4'hf);
            er = (i[2:1] == 2'b00) || (i[2:1] == 2'b11);
            ef = (i[2:1] == 2'b01) || (i[2:1] == 2'b11);
            edge_run(1'b1);
            chk("trigger_rise", {31'h0, er}, {28'h0, nt}); // selected edge
            chk("capture_rise", {31'h0, er & i[0]}, {28'h0, nc}); // enable gates
            edge_run(1'b0);
            chk("trigger_fall", {31'h0, ef}, {28'h0, nt}); // selected edge
            chk("capture_fall", {31'h0, ef & i[0]}, {28'h0, nc}); // enable gates
        end
        // counter load, readback and half-word lanes
        wr(CNT_OFFSET, 32'h1234_5678, 4'hf);
        rd(CNT_OFFSET);
        chk("counter", 32'h1234_5678, rdata); // word access
        chk("counter_narrow", 32'h0000_5678, counter_narrow); // 16-bit twin
        wr(CNT_OFFSET, 32'habcd_0000, 4'hc);
        rd(CNT_OFFSET);
        chk("counter_high_half", 32'habcd_5678, rdata); // half-word
        wr(CNT_OFFSET, 32'h0000_1111, 4'h3);
        rd(CNT_OFFSET);
        chk("counter_low_half", 32'habcd_1111, rdata); // half-word
        chk("counter_narrow_half", 32'h0000_1111, counter_narrow);
        // wrap at the width of each instance, divider at zero
        wr(CNT_OFFSET, 32'hffff_fffe, 4'hf);
        run_ticks(3);
        chk("counter_wrap", 32'h0000_0001, counter_value);
        chk("counter_narrow_wrap", 32'h0000_0001, counter_narrow);
        // a new prescale value waits for the update event
        wr(CNT_OFFSET, 32'h0000_0000, 4'hf);
        wr(PSC_OFFSET, 32'h0000_0003, 4'hf);
        rd(PSC_OFFSET);
        chk("prescale", 32'h0000_0003, rdata);
        chk("shadow_held", 32'h0000_0000, {16'h0000, prescale_shadow});
        run_ticks(16);
        chk("count_before_update", 32'h0000_0010, counter_value); // old divider
        pulse_update();
        chk("shadow_loaded", 32'h0000_0003, {16'h0000, prescale_shadow});
        wr(CNT_OFFSET, 32'h0000_0000, 4'hf);
        run_ticks(16);
        chk("count_div4", 32'h0000_0004, counter_value); // divide by value plus one
        wr(PSC_OFFSET, 32'hffff_0001, 4'h3);
        wr(PSC_OFFSET, 32'h0007_0000, 4'hc);
        rd(PSC_OFFSET);
        chk("prescale_half", 32'h0000_0001, rdata); // half-word
        wr(CNT_OFFSET, 32'h0000_0000, 4'hf);
        run_ticks(8);
        chk("count_still_div4", 32'h0000_0002, counter_value);
        pulse_update();
        wr(CNT_OFFSET, 32'h0000_0000, 4'hf);
        run_ticks(8);
        chk("count_div2", 32'h0000_0004, counter_value);
        // second reset in mid-run
        wr(CHEN_OFFSET, 32'h0000_000b, 4'hf);
        reset_check();
        summarize();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("Error watchdog expected finish seen timeout");
        summarize();
    end

endmodule // test_timer_channel0_counter_prescaler
